// file: src/ccr_pkg.sv
// constants for the converter configuration register block
// assumes a 16-bit serial frame, msb first, write flag in bit 15
package ccr_pkg;
    // frame layout
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam int WR_BIT = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 8;
    // register addresses, bits 14:8 of the frame
    localparam logic [6:0] ADDR_SWITCH = 7'h05;
    localparam logic [6:0] ADDR_CTRL = 7'h06;
    localparam logic [6:0] ADDR_SETUP_A = 7'h09;
    localparam logic [6:0] ADDR_DELAY = 7'h0A;
    // reset values
    localparam logic [7:0] RST_SWITCH = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_SETUP_A = 8'h08;
    localparam logic [7:0] RST_DELAY = 8'h80;
    localparam logic [15:0] RST_REPLY = 16'h0000;
    // switching mode fields
    localparam int SW_DEV = 0;
    localparam int SW_RATE = 1;
    localparam int SW_SPREAD = 2;
    localparam int SW_GND = 3;
    localparam int SW_VIN = 4;
    localparam int SW_CCM = 5;
    localparam int SW_DCM = 6;
    // device control fields
    localparam int CT_IDLE = 0;
    localparam int CT_SOFT_RESET_CMD = 1;
    localparam int CT_CLR = 2;
    localparam int CT_TRIM = 3;
    localparam int CT_SLOPE_LO = 4;
    localparam int CT_SLOPE_HI = 5;
    localparam int CT_GM = 6;
    localparam int CT_SAT = 7;
    // float switch setup fields
    localparam int FS_JUMP_HI = 3;
    localparam int FS_DONE = 4;
    localparam int FS_START = 5;
    localparam int FS_LIM = 6;
    localparam int FS_SAT = 7;
    // jump code 0 means the largest ratio
    localparam logic [3:0] JUMP_MAX_CODE = 4'h0;
    localparam logic [4:0] JUMP_MAX_STEPS = 5'h10;
endpackage

// file: src/ccr_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes pins are asynchronous to clk and change slowly against it
`timescale 1ns/1ps
`default_nettype none
module ccr_pin_sync
    import ccr_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pins and filtered levels
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // a level counts only once stages two and three agree
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1[i] <= INIT[i];
                    stage2[i] <= INIT[i];
                    stage3[i] <= INIT[i];
                    level[i] <= INIT[i];
                end else begin
                    stage1[i] <= pinIn[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: src/ccr_spi_frame.sv
// serial frame engine: input sampled on sck fall, output changed on sck rise
// assumes filtered pin levels; sck must stay well below clk / 8
`timescale 1ns/1ps
`default_nettype none
module ccr_spi_frame
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filtered pin levels
    input wire logic csnLvl,
    input wire logic sckLvl,
    input wire logic sdiLvl,
    // reply for the next frame, received word
    input wire logic [15:0] reply,
    output logic frameValid,
    output logic [15:0] frameWord,
    // serial out
    output logic sdo,
    output logic sdoOe_n
);
    logic csnPrev;
    logic sckPrev;
    logic [4:0] bitCount;
    logic [15:0] rxShift;
    logic [15:0] txShift;
    logic csnFall;
    logic csnRise;
    logic sckRise;
    logic sckFall;

    assign csnFall = csnPrev & ~csnLvl;
    assign csnRise = ~csnPrev & csnLvl;
    assign sckRise = ~sckPrev & sckLvl & ~csnLvl;
    assign sckFall = sckPrev & ~sckLvl & ~csnLvl;

    always_ff @(posedge clk) begin
        if (rst) begin
            csnPrev <= 1'b1;
            sckPrev <= 1'b0;
        end else begin
            csnPrev <= csnLvl;
            sckPrev <= sckLvl;
        end
    end

    // count saturates past 16 so long frames are dropped, not wrapped
    always_ff @(posedge clk) begin
        if (rst || csnFall) begin
            bitCount <= 5'h00;
            rxShift <= 16'h0000;
        end else if (sckFall) begin
            rxShift <= {rxShift[14:0], sdiLvl};
            if (bitCount <= FRAME_BITS) begin
                bitCount <= bitCount + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frameValid <= 1'b0;
            frameWord <= 16'h0000;
        end else begin
            frameValid <= csnRise && (bitCount == FRAME_BITS);
            if (csnRise) begin
                frameWord <= rxShift;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txShift <= 16'h0000;
            sdo <= 1'b0;
            sdoOe_n <= 1'b1;
        end else begin
            sdoOe_n <= csnLvl;
            if (csnFall) begin
                txShift <= reply;
            end else if (sckRise) begin
                sdo <= txShift[15];
                txShift <= {txShift[14:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// file: src/ccr_converter_config.sv
// converter configuration register bank behind the serial port
// assumes a serial host on the pins and analog loop logic on the outputs
// How it works
// - switching bit 0 picks spread deviation, 0 is 16 percent, 1 is 8.
// - switching bit 2 enables spread spectrum, reset off.
// - switching bit 4 set disables input voltage feedback, reset enabled.
// - switching bit 5 set forces continuous conduction during soft start.
// - switching bit 6 set holds fourth bridge transistor off.
// - control bit 0 set selects idle, reset active.
// - writing 1 to control bit 2 clears latched faults.
// - control bit 3 selects trim from last calibration, else host value.
// - control bits 5:4 set slope compensation strength, reset nominal.
// - control bit 6 boosts amplifier gain while current is below 80 percent.
// - control bit 7 reduces amplifier saturation current, reset inactive.
// - setup bits 3:0 set jump steps, code 0 means 16, reset 8.
// - setup bit 4 reads done after routine, cleared when start is set.
// - setup bit 5 written 1 starts the float switch routine.
// - setup bit 6 picks discharge current limit, two thirds or half.
// - setup bit 7 reduces amplifier current only while routine runs.
// - delay register holds routine delay code, reset 80 hex.
// - unmapped writes ignored, unmapped reads answer the diagnosis frame.
// - frames are 16 bits, bit 15 write flag, address above data.
`timescale 1ns/1ps
`default_nettype none
module ccr_converter_config
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial port pins
    input wire logic spiCs_n,
    input wire logic spiSck,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOe_n,
    // status from the rest of the device
    input wire logic [15:0] stdDiagFrame,
    input wire logic floatRoutineDoneIn,
    input wire logic currentBelow80,
    // switching mode controls
    output logic spreadDeviationSel,
    output logic spreadRateSel,
    output logic spreadEnable,
    output logic groundShortCheckOff,
    output logic inputFeedbackDisable,
    output logic forcedContinuousInSoftstart,
    output logic discontinuousEnable,
    // device controls
    output logic idleMode,
    output logic softResetCmd,
    output logic clearLatchedFaultsCmd,
    output logic autoTrimSourceSel,
    output logic [1:0] slopeComp,
    output logic ampGainBoost,
    output logic ampGainBoostActive,
    output logic ampSatCurrentReduce,
    // float switch controls
    output logic [3:0] jumpRatioCode,
    output logic [4:0] jumpRatioSteps,
    output logic floatRoutineDone,
    output logic floatRoutineStart,
    output logic dischargeLimitReduce,
    output logic ampCurrentReduceInRoutine,
    output logic ampCurrentReduceActive,
    output logic [7:0] floatRoutineDelay
);
    logic csnLvl;
    logic sckLvl;
    logic sdiLvl;
    logic belowLvl;
    logic frameValid;
    logic [15:0] frameWord;
    logic [15:0] replyWord;
    logic [6:0] addr;
    logic [7:0] wrData;
    logic isWrite;
    logic wrSwitch;
    logic wrCtrl;
    logic wrSetupA;
    logic wrDelay;
    logic mapped;
    logic softResetHit;
    logic [7:0] readByte;

    // current level comes from the analog side, so it is filtered like a pin
    ccr_pin_sync #(
        .WIDTH(4),
        .INIT(4'h1)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn({currentBelow80, spiSdi, spiSck, spiCs_n}),
        .level({belowLvl, sdiLvl, sckLvl, csnLvl})
    );

    ccr_spi_frame u_frame (
        .clk(clk),
        .rst(rst),
        .csnLvl(csnLvl),
        .sckLvl(sckLvl),
        .sdiLvl(sdiLvl),
        .reply(replyWord),
        .frameValid(frameValid),
        .frameWord(frameWord),
        .sdo(spiSdo),
        .sdoOe_n(spiSdoOe_n)
    );

    always_comb begin
        addr = frameWord[ADDR_HI:ADDR_LO];
        wrData = frameWord[7:0];
        isWrite = frameWord[WR_BIT];
    end

    always_comb begin
        mapped = (addr == ADDR_SWITCH) || (addr == ADDR_CTRL)
            || (addr == ADDR_SETUP_A) || (addr == ADDR_DELAY);
        wrSwitch = frameValid && isWrite && (addr == ADDR_SWITCH);
        wrCtrl = frameValid && isWrite && (addr == ADDR_CTRL);
        wrSetupA = frameValid && isWrite && (addr == ADDR_SETUP_A);
        wrDelay = frameValid && isWrite && (addr == ADDR_DELAY);
    end

    assign softResetHit = wrCtrl && wrData[CT_SOFT_RESET_CMD];

    // spread and ground check fields, share the same write
    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            spreadDeviationSel <= RST_SWITCH[SW_DEV];
            spreadRateSel <= RST_SWITCH[SW_RATE];
            spreadEnable <= RST_SWITCH[SW_SPREAD];
            groundShortCheckOff <= RST_SWITCH[SW_GND];
        end else if (wrSwitch) begin
            spreadDeviationSel <= wrData[SW_DEV];
            spreadRateSel <= wrData[SW_RATE];
            spreadEnable <= wrData[SW_SPREAD];
            groundShortCheckOff <= wrData[SW_GND];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            inputFeedbackDisable <= RST_SWITCH[SW_VIN];
            forcedContinuousInSoftstart <= RST_SWITCH[SW_CCM];
            discontinuousEnable <= RST_SWITCH[SW_DCM];
        end else if (wrSwitch) begin
            inputFeedbackDisable <= wrData[SW_VIN];
            forcedContinuousInSoftstart <= wrData[SW_CCM];
            discontinuousEnable <= wrData[SW_DCM];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            idleMode <= RST_CTRL[CT_IDLE];
            autoTrimSourceSel <= RST_CTRL[CT_TRIM];
            slopeComp <= RST_CTRL[CT_SLOPE_HI:CT_SLOPE_LO];
            ampGainBoost <= RST_CTRL[CT_GM];
            ampSatCurrentReduce <= RST_CTRL[CT_SAT];
        end else if (wrCtrl) begin
            idleMode <= wrData[CT_IDLE];
            autoTrimSourceSel <= wrData[CT_TRIM];
            slopeComp <= wrData[CT_SLOPE_HI:CT_SLOPE_LO];
            ampGainBoost <= wrData[CT_GM];
            ampSatCurrentReduce <= wrData[CT_SAT];
        end
    end

    // one-cycle command pulses; nothing is stored, so reads give 0
    always_ff @(posedge clk) begin
        if (rst) begin
            softResetCmd <= 1'b0;
            clearLatchedFaultsCmd <= 1'b0;
        end else begin
            softResetCmd <= softResetHit;
            clearLatchedFaultsCmd <= wrCtrl && wrData[CT_CLR];
        end
    end

    // gain boost only acts below 80 percent of target current
    always_ff @(posedge clk) begin
        if (rst) begin
            ampGainBoostActive <= 1'b0;
            ampCurrentReduceActive <= 1'b0;
        end else begin
            ampGainBoostActive <= ampGainBoost && belowLvl;
            // reduction only while the routine runs
            ampCurrentReduceActive <= ampCurrentReduceInRoutine && floatRoutineStart;
        end
    end

    // jump code and decoded steps, limit, enable
    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            jumpRatioCode <= RST_SETUP_A[FS_JUMP_HI:0];
            jumpRatioSteps <= {1'b0, RST_SETUP_A[FS_JUMP_HI:0]};
            dischargeLimitReduce <= RST_SETUP_A[FS_LIM];
            ampCurrentReduceInRoutine <= RST_SETUP_A[FS_SAT];
        end else if (wrSetupA) begin
            jumpRatioCode <= wrData[FS_JUMP_HI:0];
            if (wrData[FS_JUMP_HI:0] == JUMP_MAX_CODE) begin
                jumpRatioSteps <= JUMP_MAX_STEPS;
            end else begin
                jumpRatioSteps <= {1'b0, wrData[FS_JUMP_HI:0]};
            end
            dischargeLimitReduce <= wrData[FS_LIM];
            ampCurrentReduceInRoutine <= wrData[FS_SAT];
        end
    end

    // start bit; routine completion drops it unless a write comes too
    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            floatRoutineStart <= RST_SETUP_A[FS_START];
        end else if (wrSetupA) begin
            floatRoutineStart <= wrData[FS_START];
        end else if (floatRoutineDoneIn) begin
            floatRoutineStart <= 1'b0;
        end
    end

    // done flag, a completion in the clearing cycle still sets it
    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            floatRoutineDone <= RST_SETUP_A[FS_DONE];
        end else if (floatRoutineDoneIn) begin
            floatRoutineDone <= 1'b1;
        end else if (wrSetupA && wrData[FS_START]) begin
            floatRoutineDone <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || softResetHit) begin
            floatRoutineDelay <= RST_DELAY;
        end else if (wrDelay) begin
            floatRoutineDelay <= wrData;
        end
    end

    // command bits are never held, so they read back as zero
    always_comb begin
        readByte = 8'h00;
        unique case (addr)
            ADDR_SWITCH: begin
                readByte = {1'b0, discontinuousEnable, forcedContinuousInSoftstart,
                    inputFeedbackDisable, groundShortCheckOff, spreadEnable,
                    spreadRateSel, spreadDeviationSel};
            end
            ADDR_CTRL: begin
                readByte = {ampSatCurrentReduce, ampGainBoost, slopeComp,
                    autoTrimSourceSel, 1'b0, 1'b0, idleMode};
            end
            ADDR_SETUP_A: begin
                readByte = {ampCurrentReduceInRoutine, dischargeLimitReduce,
                    floatRoutineStart, floatRoutineDone, jumpRatioCode};
            end
            ADDR_DELAY: begin
                readByte = floatRoutineDelay;
            end
            default: begin
                readByte = 8'h00;
            end
        endcase
    end

    // reply goes out in the next frame; unmapped or write gives diagnosis
    always_ff @(posedge clk) begin
        if (rst) begin
            replyWord <= RST_REPLY;
        end else if (frameValid) begin
            if (!isWrite && mapped) begin
                replyWord <= {1'b0, addr, readByte};
            end else begin
                replyWord <= stdDiagFrame;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    switch_write_a: assert property (
        wrSwitch |=> {discontinuousEnable, forcedContinuousInSoftstart, inputFeedbackDisable,
            spreadEnable, spreadRateSel, spreadDeviationSel}
            == {$past(wrData[6:4]), $past(wrData[2:0])})
        else $error("switching mode fields not loaded");

    ctrl_write_a: assert property (
        (wrCtrl && !wrData[CT_SOFT_RESET_CMD]) |=> (idleMode == $past(wrData[0]))
            && (autoTrimSourceSel == $past(wrData[3])) && (slopeComp == $past(wrData[5:4]))
            && (ampSatCurrentReduce == $past(wrData[7])))
        else $error("device control fields not loaded");

    soft_reset_a: assert property (
        softResetHit |=> softResetCmd && !spreadEnable && (floatRoutineDelay == RST_DELAY)
            && (jumpRatioSteps == 5'h08) ##1 !softResetCmd)
        else $error("soft reset did not restore defaults or pulse once");

    clear_pulse_a: assert property (
        (wrCtrl && wrData[CT_CLR]) |=> clearLatchedFaultsCmd ##1 !clearLatchedFaultsCmd)
        else $error("fault clear pulse wrong");

    gain_boost_a: assert property (
        ampGainBoostActive == ($past(ampGainBoost) && $past(belowLvl)))
        else $error("gain boost active without cause");

    jump_steps_a: assert property (
        (wrSetupA && wrData[3:0] == 4'h0) |=> (jumpRatioSteps == 5'h10) [*2])
        else $error("jump code zero not decoded as sixteen steps");

    done_set_a: assert property (
        floatRoutineDoneIn |=> floatRoutineDone && !$past(softResetHit) || !floatRoutineDone
            && $past(softResetHit))
        else $error("done flag lost a completion");

    done_clear_a: assert property (
        (wrSetupA && wrData[FS_START] && !floatRoutineDoneIn) |=> !floatRoutineDone && floatRoutineStart)
        else $error("start did not clear done");

    routine_reduce_a: assert property (
        (wrSetupA && !softResetHit) |=> (dischargeLimitReduce == $past(wrData[6]))
            ##1 (ampCurrentReduceActive == (ampCurrentReduceInRoutine && $past(floatRoutineStart))))
        else $error("float routine options wrong");

    delay_write_a: assert property (
        wrDelay |=> floatRoutineDelay == $past(wrData))
        else $error("delay code not loaded");

    unmapped_a: assert property (
        (frameValid && !mapped) |=> $stable(floatRoutineDelay) && $stable(idleMode)
            && (replyWord == $past(stdDiagFrame)))
        else $error("unmapped access had an effect");

    read_reply_a: assert property (
        (frameValid && !isWrite && mapped) |=> (replyWord[7:0] == $past(readByte))
            && (replyWord[14:8] == $past(addr)))
        else $error("read reply wrong");

    soft_reset_c: cover property (softResetHit ##1 softResetCmd);
    routine_run_c: cover property (wrSetupA && wrData[FS_START] ##[1:1000] floatRoutineDone);
    read_back_c: cover property (frameValid && !isWrite && (addr == ADDR_CTRL));
    unmapped_c: cover property (frameValid && !mapped);
endmodule
`default_nettype wire

// file: bench/ccr_spi_host.sv
// serial host model for the register bank, mode 1, msb first
// assumes clk paces the bit timing; sck rests low between frames
`timescale 1ns/1ps
`default_nettype none
module ccr_spi_host (
    // pacing clock
    input wire logic clk,
    // serial pins
    output logic spiCs_n,
    output logic spiSck,
    output logic spiSdi,
    input wire logic spiSdo
);
    initial begin
        spiCs_n = 1'b1;
        spiSck = 1'b0;
        spiSdi = 1'b0;
    end
    // sixteen bit frame
    // a short count lets the bench send a truncated frame
    task automatic xfer(input logic [15:0] tx, input int n, input int half, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk) #1 spiCs_n = 1'b0;
        repeat (half) @(posedge clk);
        for (int i = 15; i > 15 - n; i--) begin
            #1 spiSck = 1'b1;
            spiSdi = tx[i];
            repeat (half) @(posedge clk);
            #1 spiSck = 1'b0;
            rx = {rx[14:0], spiSdo};
            repeat (half) @(posedge clk);
        end
        #1 spiCs_n = 1'b1;
        // no pull on the data line: show a changed level once released
        spiSdi = ~spiSdi;
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: bench/tb_converter_config_registers.sv
// self-checking bench for the converter configuration register bank
// assumes ccr_spi_host as serial host and the ccr_pkg constants
`timescale 1ns/1ps
`default_nettype none
module tb_converter_config_registers;
    import ccr_pkg::*;
    logic clk, rst, below80, doneIn, done;
    logic [15:0] diag;
    wire logic spiCs_n, spiSck, spiSdi, spiSdo, sdoOe_n, gmAct, satAct;
    wire logic [6:0] swOut;
    wire logic [7:0] ctOut, fsOut, dly;
    wire logic [4:0] jSteps;
    logic [6:0] adr [4] = '{ADDR_SWITCH, ADDR_CTRL, ADDR_SETUP_A, ADDR_DELAY};
    logic [7:0] sh [4];
    int seed, bad_count, check_count, clrN = 0, swrN = 0, expClr = 0;

    ccr_spi_host host (.clk(clk), .spiCs_n(spiCs_n), .spiSck(spiSck), .spiSdi(spiSdi), .spiSdo(spiSdo));
    ccr_converter_config dut (.clk(clk), .rst(rst), .spiCs_n(spiCs_n), .spiSck(spiSck), .spiSdi(spiSdi),
        .spiSdo(spiSdo), .spiSdoOe_n(sdoOe_n), .stdDiagFrame(diag), .floatRoutineDoneIn(doneIn),
        .currentBelow80(below80), .spreadDeviationSel(swOut[0]), .spreadRateSel(swOut[1]),
        .spreadEnable(swOut[2]), .groundShortCheckOff(swOut[3]), .inputFeedbackDisable(swOut[4]),
        .forcedContinuousInSoftstart(swOut[5]), .discontinuousEnable(swOut[6]), .idleMode(ctOut[0]),
        .softResetCmd(ctOut[1]), .clearLatchedFaultsCmd(ctOut[2]), .autoTrimSourceSel(ctOut[3]),
        .slopeComp(ctOut[5:4]), .ampGainBoost(ctOut[6]), .ampGainBoostActive(gmAct),
        .ampSatCurrentReduce(ctOut[7]), .jumpRatioCode(fsOut[3:0]), .jumpRatioSteps(jSteps),
        .floatRoutineDone(fsOut[4]), .floatRoutineStart(fsOut[5]), .dischargeLimitReduce(fsOut[6]),
        .ampCurrentReduceInRoutine(fsOut[7]), .ampCurrentReduceActive(satAct), .floatRoutineDelay(dly));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // command pulses are counted so a stretched pulse shows up
    always @(posedge clk) begin
        if (ctOut[1] === 1'b1) swrN++;
        if (ctOut[2] === 1'b1) clrN++;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [4:0] steps(input logic [3:0] c);
        return (c == 4'h0) ? 5'h10 : {1'b0, c};
    endfunction
    // the done bit is status, so the written bit 4 never reads back
    function automatic logic [7:0] rbExp(input int i);
        return (i == 2) ? {sh[2][7:5], done, sh[2][3:0]} : sh[i];
    endfunction
    task automatic setDef();
        sh = '{RST_SWITCH, RST_CTRL, RST_SETUP_A, RST_DELAY};
        done = 1'b0;
    endtask
    task automatic frm(input logic [15:0] tx, input int n, output logic [15:0] rx);
        host.xfer(tx, n, 8 + {$random(seed)} % 5, rx);
    endtask
    task automatic wrReg(input int i, input logic [7:0] d);
        logic [15:0] r;
        frm({1'b1, adr[i], d}, 16, r);
        if (i == 1 && d[1])
            setDef();
        else
            sh[i] = d & ((i == 0) ? 8'h7F : (i == 1) ? 8'hF9 : 8'hFF);
        if (i == 1 && d[2]) expClr++;
        if (i == 2 && d[5]) done = 1'b0;
    endtask
    // second frame clocks out the reply of the first
    task automatic rd(input logic [6:0] a, output logic [15:0] p, output logic [15:0] r);
        frm({1'b0, a, 8'h00}, 16, p);
        frm({1'b0, 7'h7F, 8'h00}, 16, r);
    endtask
    task automatic rdAll();
        logic [15:0] p, r;
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], p, r);
            chk("readback", {1'b0, adr[i], rbExp(i)}, r);
        end
    endtask
    task automatic cmpAll();
        chk("switching", 16'(sh[0]), 16'({1'b0, swOut}));
        chk("control", 16'(sh[1]), 16'(ctOut));
        chk("setup", 16'(rbExp(2)), 16'(fsOut));
        chk("delay", 16'(sh[3]), 16'(dly));
        chk("steps", 16'(steps(sh[2][3:0])), 16'(jSteps));
        chk("gainAct", 16'(sh[1][6] & below80), 16'(gmAct));
        chk("satAct", 16'(sh[2][7] & sh[2][5]), 16'(satAct));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [7:0] d;
        logic [15:0] p, r;
        seed = 99;
        bad_count = 0;
        check_count = 0;
        rst = 1'b1;
        below80 = 1'b0;
        doneIn = 1'b0;
        diag = 16'h0000;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        setDef();
        chk("sdoOe", 16'h0001, 16'(sdoOe_n));
        cmpAll();
        rdAll();
        // random writes; the setup write walks every jump code
        for (int i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            #1 diag = 16'($random(seed));
            below80 = d[0];
            wrReg(0, d);
            wrReg(1, d & 8'hFD);
            wrReg(2, {d[7:4], i[3:0]});
            wrReg(3, ~d);
            rd(adr[i % 4], p, r);
            chk("writeReply", diag, p);
            chk("readback", {1'b0, adr[i % 4], rbExp(i % 4)}, r);
            cmpAll();
            chk("clearPulses", 16'(expClr), 16'(clrN));
        end
        frm({1'b1, 7'h07, 8'hFF}, 16, p);
        rd(7'h07, p, r);
        chk("unmappedRead", diag, r);
        cmpAll();
        frm({1'b1, ADDR_DELAY, ~sh[3]}, 15, p);
        cmpAll();
        wrReg(2, 8'hA3);
        cmpAll();
        @(posedge clk) #1 doneIn = 1'b1;
        @(posedge clk) #1 doneIn = 1'b0;
        repeat (2) @(posedge clk);
        sh[2][5] = 1'b0;
        done = 1'b1;
        cmpAll();
        rd(ADDR_SETUP_A, p, r);
        chk("doneRead", {1'b0, ADDR_SETUP_A, rbExp(2)}, r);
        wrReg(2, 8'h23);
        cmpAll();
        wrReg(1, 8'h02);
        chk("resetPulses", 16'h0001, 16'(swrN));
        cmpAll();
        rdAll();
        print_verdict();
    end
endmodule
`default_nettype wire
